// ==== hpt_pkg.sv ====
// package of constants and types for the channel 13-16 high-pass and pattern block
package hpt_pkg;

  localparam int unsigned SAMPLE_W  = 14;
  localparam int unsigned FRAC_W    = 12;
  localparam int unsigned EXT_W     = SAMPLE_W + FRAC_W + 2;
  localparam int unsigned NCH       = 4;
  localparam int unsigned CODE_W    = 3;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned REG_W     = 16;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CTRL57   = 12'h039;
  localparam logic [ADDR_W-1:0] IDX_PAT59    = 12'h03b;
  localparam logic [ADDR_W-1:0] IDX_MODE     = 12'h03e;
  localparam logic [ADDR_W-1:0] IDX_STATUS   = 12'h03f;
  localparam logic [ADDR_W-1:0] ADDR_CTRL57  = IDX_CTRL57 << 2;
  localparam logic [ADDR_W-1:0] ADDR_PAT59   = IDX_PAT59 << 2;
  localparam logic [ADDR_W-1:0] ADDR_MODE    = IDX_MODE << 2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = IDX_STATUS << 2;

  localparam logic [REG_W-1:0]  RST_CTRL57   = 16'h0000;
  localparam logic [REG_W-1:0]  RST_PAT59    = 16'h0000;
  localparam logic [REG_W-1:0]  RST_MODE     = 16'h0000;

  // field positions in the group control register
  localparam int unsigned PRBS13_BIT  = 15;
  localparam int unsigned PRBS16_BIT  = 12;
  localparam int unsigned CODE13_LSB  = 9;
  localparam int unsigned CODE14_LSB  = 6;
  localparam int unsigned EXP_LSB     = 1;
  localparam int unsigned EXP_W       = 4;
  localparam int unsigned HPF_EN_BIT  = 0;
  // field positions in the second pattern register
  localparam int unsigned CODE15_LSB  = 5;
  localparam int unsigned CODE16_LSB  = 2;
  // own mode and status bits
  localparam int unsigned MODE_BIT    = 0;
  localparam int unsigned ST_HPF_BIT  = 0;
  localparam int unsigned ST_MODE_BIT = 1;
  localparam int unsigned ST_MISM_BIT = 2;

  typedef struct packed {
    logic                               valid;
    logic [NCH-1:0][SAMPLE_W-1:0]       data;
  } hpt_smp_s;

  typedef struct packed {
    logic [NCH-1:0]                     prbs;
    logic [NCH-1:0][CODE_W-1:0]         code;
  } hpt_pat_s;

  typedef struct packed {
    logic [REG_W-1:0]                   r57;
    logic [REG_W-1:0]                   r59;
    logic [REG_W-1:0]                   mode;
    logic                               armed;
    logic [31:0]                        prdata;
    logic                               pslverr;
    logic [NCH-1:0][SAMPLE_W-1:0]       x1;
    logic [NCH-1:0][EXT_W-1:0]          y1;
    hpt_smp_s                           out;
    hpt_pat_s                           pat;
  } hpt_state_s;

endpackage

// ==== hpt_rx.sv ====
// receiver model capturing the filtered sample stream
`timescale 1ns/100ps
`default_nettype none
module hpt_rx
  import hpt_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     nrst,
  input  wire hpt_smp_s smp,
  output hpt_smp_s      last,
  output int            count
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last  <= '0;
      count <= 0;
    end else if (smp.valid) begin
      last  <= smp;
      count <= count + 1;
    end
  end
endmodule // hpt_rx
`default_nettype wire

// ==== hpt_top.sv ====
// channel 13-16 high-pass filter and per-output test pattern control with apb registers
// Contract
// R1: bits 15..12 enable prbs on outputs 13..16
// R2: codes 11-9 for output 13, 8-6 output 14
// R3: second register codes 7-5 out15, 4-2 out16
// R4: enabled filter computes scaled difference plus feedback
// R5: software keeps exponent between 2 and 10
// R6: one exponent for all four, only when enabled
// R7: bit 0 enables filter, reset bypasses it
// R8: software matches enable with channels 9-12
// R9: software writes zero to reserved bits
`timescale 1ns/100ps
`default_nettype none
module hpt_top
  import hpt_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    ce,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    highpass_enable_grp3,
  input  wire hpt_smp_s                smp_in,
  output hpt_smp_s                     smp_out,
  output hpt_pat_s                     pat_out
);

  localparam logic [EXT_W-1:0] Y_MAX = EXT_W'((2 ** (SAMPLE_W - 1) - 1)) << FRAC_W;
  localparam logic [EXT_W-1:0] Y_MIN = (~(EXT_W'((2 ** (SAMPLE_W - 1))) << FRAC_W)) + EXT_W'(1);

  hpt_state_s                          st_reg;
  hpt_state_s                          st_next;

  logic                                hpf_en;
  logic                                per_mode;
  logic [EXP_W-1:0]                    k_exp;
  logic [5:0]                          k1;
  logic [5:0]                          k2;
  logic [5:0]                          k3;
  logic                                setup;
  logic                                access;
  logic [NCH-1:0][CODE_W-1:0]          codes;
  logic [SAMPLE_W:0]                   diff;
  logic signed [EXT_W-1:0]             s_ext;
  logic signed [EXT_W-1:0]             y_ext;
  logic signed [EXT_W-1:0]             y_lim;
  logic [REG_W-1:0]                    status;

  assign hpf_en   = st_reg.r57[HPF_EN_BIT];
  assign per_mode = st_reg.mode[MODE_BIT];
  assign k_exp    = st_reg.r57[EXP_LSB +: EXP_W];
  assign k1       = {2'b00, k_exp};
  assign k2       = {1'b0, k_exp, 1'b0};
  assign k3       = 6'({2'b00, k_exp} + {1'b0, k_exp, 1'b0});
  assign setup    = psel & ~penable;
  assign access   = psel & penable & st_reg.armed;

  assign codes[0] = st_reg.r57[CODE13_LSB +: CODE_W];  // [R2]
  assign codes[1] = st_reg.r57[CODE14_LSB +: CODE_W];  // [R2]
  assign codes[2] = st_reg.r59[CODE15_LSB +: CODE_W];  // [R3]
  assign codes[3] = st_reg.r59[CODE16_LSB +: CODE_W];  // [R3]

  always_comb begin
    status = '0;
    status[ST_HPF_BIT]  = hpf_en;
    status[ST_MODE_BIT] = per_mode;
    // flags a group enable that differs from channels 9-12
    status[ST_MISM_BIT] = hpf_en ^ highpass_enable_grp3;
  end

  assign pready  = ce & access;
  assign prdata  = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign smp_out = st_reg.out;
  assign pat_out = st_reg.pat;

  always_comb begin
    st_next = st_reg;
    diff    = '0;
    s_ext   = '0;
    y_ext   = '0;
    y_lim   = '0;

    // apb setup: decode and latch read data
    if (setup) begin
      st_next.armed   = 1'b1;
      st_next.pslverr = 1'b0;
      st_next.prdata  = '0;
      if (paddr == ADDR_CTRL57) begin
        st_next.prdata[REG_W-1:0] = st_reg.r57;
      end else if (paddr == ADDR_PAT59) begin
        st_next.prdata[REG_W-1:0] = st_reg.r59;
      end else if (paddr == ADDR_MODE) begin
        st_next.prdata[REG_W-1:0] = st_reg.mode;
      end else if (paddr == ADDR_STATUS) begin
        st_next.prdata[REG_W-1:0] = status;
      end else begin
        st_next.pslverr = 1'b1;
      end
    end

    // apb access: writes land here
    if (access) begin
      st_next.armed = 1'b0;
      if (pwrite) begin
        if (paddr == ADDR_CTRL57) begin
          st_next.r57 = pwdata[REG_W-1:0];
        end else if (paddr == ADDR_PAT59) begin
          st_next.r59 = pwdata[REG_W-1:0];
        end else if (paddr == ADDR_MODE) begin
          st_next.mode = pwdata[REG_W-1:0];
        end
      end
    end

    // pattern selection only under per-output mode
    for (int i = 0; i < NCH; i++) begin
      st_next.pat.prbs[i] = per_mode & st_reg.r57[PRBS13_BIT - i];  // [R1]
      st_next.pat.code[i] = per_mode ? codes[i] : '0;  // [R2] [R3]
    end

    // sample path, one exponent shared by all channels
    st_next.out.valid = smp_in.valid;
    if (smp_in.valid) begin
      for (int i = 0; i < NCH; i++) begin
        st_next.x1[i] = smp_in.data[i];
        if (hpf_en) begin  // [R6] [R7]
          diff  = (SAMPLE_W+1)'(signed'({smp_in.data[i][SAMPLE_W-1], smp_in.data[i]})
                  - signed'({st_reg.x1[i][SAMPLE_W-1], st_reg.x1[i]}));
          s_ext = signed'(EXT_W'(signed'(diff)) <<< FRAC_W) + signed'(st_reg.y1[i]);
          // gain 2^k/(2^k+1) as 1 - 2^-k + 2^-2k - 2^-3k
          y_ext = s_ext - (s_ext >>> k1) + (s_ext >>> k2) - (s_ext >>> k3);  // [R4] [R6]
          if (y_ext > signed'(Y_MAX)) begin
            y_lim = signed'(Y_MAX);
          end else if (y_ext < signed'(Y_MIN)) begin
            y_lim = signed'(Y_MIN);
          end else begin
            y_lim = y_ext;
          end
          st_next.y1[i]       = y_lim;
          st_next.out.data[i] = SAMPLE_W'(y_lim >>> FRAC_W);  // [R4]
        end else begin
          // bypass, feedback history cleared
          st_next.y1[i]       = '0;
          st_next.out.data[i] = smp_in.data[i];  // [R7]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg      <= '0;
      st_reg.r57  <= RST_CTRL57;  // [R7]
      st_reg.r59  <= RST_PAT59;
      st_reg.mode <= RST_MODE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_prbs_out13;
    ce ##0 st_reg.mode[MODE_BIT] ##0 st_reg.r57[PRBS13_BIT] ##0 $stable(st_reg.r57)
      |=> ce |-> pat_out.prbs[0];
  endproperty
  a_prbs_out13: assert property (p_prbs_out13) else $error("prbs 13 not enabled");  // [R1]

  property p_prbs_off;
    ce && !st_reg.mode[MODE_BIT] |=> pat_out.prbs == '0 && pat_out.code[0] == '0;
  endproperty
  a_prbs_off: assert property (p_prbs_off) else $error("pattern active without mode");  // [R1]

  property p_code14;
    ce && st_reg.mode[MODE_BIT]
      |=> pat_out.code[1] == $past(st_reg.r57[CODE14_LSB +: CODE_W]);
  endproperty
  a_code14: assert property (p_code14) else $error("output 14 code wrong");  // [R2]

  property p_code16;
    ce && st_reg.mode[MODE_BIT]
      |=> pat_out.code[3] == $past(st_reg.r59[CODE16_LSB +: CODE_W]);
  endproperty
  a_code16: assert property (p_code16) else $error("output 16 code wrong");  // [R3]

  property p_hpf_flat;
    ce && hpf_en && smp_in.valid && smp_in.data[0] == st_reg.x1[0] && st_reg.y1[0] == '0
      |=> smp_out.valid && smp_out.data[0] == '0;
  endproperty
  a_hpf_flat: assert property (p_hpf_flat) else $error("flat input not rejected");  // [R4]

  property p_same_k;
    ce && hpf_en && smp_in.valid && smp_in.data[0] == smp_in.data[3]
      && st_reg.x1[0] == st_reg.x1[3] && st_reg.y1[0] == st_reg.y1[3]
      |=> smp_out.data[0] == smp_out.data[3];
  endproperty
  a_same_k: assert property (p_same_k) else $error("channels filtered differently");  // [R6]

  property p_bypass;
    ce && !hpf_en && smp_in.valid |=> smp_out.data == $past(smp_in.data) && smp_out.valid;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered samples");  // [R7]

  property p_write57;
    pready && pwrite && paddr == ADDR_CTRL57
      |=> st_reg.r57 == $past(pwdata[REG_W-1:0]) && !pready;
  endproperty
  a_write57: assert property (p_write57) else $error("control write lost");  // [R7]

  // pattern output checks
  property p_prbs_out16;
    ce && st_reg.mode[MODE_BIT]
      |=> pat_out.prbs[3] == $past(st_reg.r57[PRBS16_BIT]);
  endproperty
  a_prbs_out16: assert property (p_prbs_out16) else $error("prbs 16 select wrong");  // [R1]

  property p_code13;
    ce && st_reg.mode[MODE_BIT]
      |=> pat_out.code[0] == $past(st_reg.r57[CODE13_LSB +: CODE_W]);
  endproperty
  a_code13: assert property (p_code13) else $error("output 13 code wrong");  // [R2]

  property p_code15;
    ce && st_reg.mode[MODE_BIT]
      |=> pat_out.code[2] == $past(st_reg.r59[CODE15_LSB +: CODE_W]);
  endproperty
  a_code15: assert property (p_code15) else $error("output 15 code wrong");  // [R3]

  property p_code_off;
    ce && !st_reg.mode[MODE_BIT] |=> pat_out.code == '0;
  endproperty
  a_code_off: assert property (p_code_off) else $error("codes active without mode");  // [R3]

  // sample stream checks
  property p_valid_lat;
    ce |=> smp_out.valid == $past(smp_in.valid);
  endproperty
  a_valid_lat: assert property (p_valid_lat) else $error("output valid latency wrong");

  property p_hold_data;
    ce && !smp_in.valid |=> smp_out.data == $past(smp_out.data);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("output data moved without valid");

  property p_x1;
    ce && smp_in.valid |=> st_reg.x1 == $past(smp_in.data);
  endproperty
  a_x1: assert property (p_x1) else $error("previous input not kept");  // [R4]

  property p_clamp;
    ce && hpf_en && smp_in.valid
      |=> signed'(st_reg.y1[0]) <= signed'(Y_MAX)
      && signed'(st_reg.y1[0]) >= signed'(Y_MIN);
  endproperty
  a_clamp: assert property (p_clamp) else $error("feedback out of range");  // [R4]

  property p_hist_clear;
    ce && !hpf_en && smp_in.valid |=> st_reg.y1 == '0;
  endproperty
  a_hist_clear: assert property (p_hist_clear) else $error("bypass kept feedback");  // [R7]

  property p_freeze;
    !ce |=> st_reg == $past(st_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  // register bus checks
  property p_zero_wait;
    (ce && setup) ##1 (ce && psel && penable) |-> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access not answered at once");

  property p_pready_once;
    pready |=> !pready;
  endproperty
  a_pready_once: assert property (p_pready_once) else $error("ready held past access");

  property p_read_ctrl;
    ce && setup && !pwrite && paddr == ADDR_CTRL57
      |=> prdata[REG_W-1:0] == $past(st_reg.r57) && prdata[31:REG_W] == '0;
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read data wrong");

  property p_unmapped;
    ce && setup && paddr != ADDR_CTRL57 && paddr != ADDR_PAT59 && paddr != ADDR_MODE
      && paddr != ADDR_STATUS |=> pslverr && prdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_err_nowrite;
    pready && pslverr
      |=> $stable(st_reg.r57) && $stable(st_reg.r59) && $stable(st_reg.mode);
  endproperty
  a_err_nowrite: assert property (p_err_nowrite) else $error("refused access wrote");

endmodule // hpt_top
`default_nettype wire

// ==== hpt_top_test.sv ====
// self-checking bench for the high-pass and test pattern block
`timescale 1ns/100ps
`default_nettype none
module hpt_top_test;
  import hpt_pkg::*;
  logic              clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, grp3 = 0, ce = 1, er;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd, d, p;
  logic              pready, pslverr;
  hpt_smp_s          smp_in = '0, smp_out, rx_last;
  hpt_pat_s          pat_out, pe;
  int                bad_count = 0, comparisons = 0, cyc = 0, rx_count, seed = 32'ha3f6;
  int                k, i, xm[NCH];
  real               g, ym[NCH];

  always #5 clk = ~clk;

  hpt_top u_hpt_top (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .highpass_enable_grp3(grp3), .smp_in(smp_in), .smp_out(smp_out),
    .pat_out(pat_out));
  hpt_rx u_hpt_rx (.clk(clk), .nrst(nrst), .smp(smp_out), .last(rx_last), .count(rx_count));

  task finish_test;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test;
    end
  end

  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one random beat on all channels, model advanced alongside
  task send(input bit en);
    hpt_smp_s s;
    int x, dv;
    s.valid = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      x = $random(seed) % 2000;
      s.data[c] = x[SAMPLE_W-1:0];
      ym[c] = en ? g * (x - xm[c] + ym[c]) : 0.0;
      if (ym[c] > 8191.0) ym[c] = 8191.0;
      if (ym[c] < -8192.0) ym[c] = -8192.0;
      xm[c] = x;
    end
    @(posedge clk) smp_in <= s;
    @(posedge clk) smp_in.valid <= 1'b0;
    @(posedge clk);
    #1;
    for (int c = 0; c < NCH; c++) begin
      dv = int'($signed(rx_last.data[c])) - int'($floor(ym[c]));
      if (en) check(32'(dv < 5 && dv > -5), 32'h1);
      else check(32'($signed(rx_last.data[c])), 32'(xm[c]));
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    apb(0, ADDR_CTRL57, 0); check(rd, 32'h0);
    apb(0, ADDR_PAT59, 0); check(rd, 32'h0);
    apb(1, 12'h100, 32'h5); check(32'(er), 32'h1);
    for (i = 0; i < 4; i++) begin
      d = ($random(seed) & 32'hffc0) | 32'(((i + 2) & 15) << 1);
      apb(1, ADDR_CTRL57, d);
      apb(0, ADDR_CTRL57, 0);
      check(rd, d);
    end
    apb(1, ADDR_MODE, 32'h1);
    apb(0, ADDR_MODE, 0);
    check(rd, 32'h1);
    for (i = 0; i < 8; i++) begin
      d = ($random(seed) & 32'hf000) | (i << 9) | (((i + 1) & 7) << 6) | 32'h4;
      p = (((i + 2) & 7) << 5) | (((i + 3) & 7) << 2);
      apb(1, ADDR_CTRL57, d);
      apb(1, ADDR_PAT59, p);
      repeat (2) @(posedge clk);
      #1;
      pe.prbs = {d[12], d[13], d[14], d[15]};
      pe.code = {p[4:2], p[7:5], d[8:6], d[11:9]};
      check(32'(pat_out), 32'(pe));
    end
    apb(0, ADDR_STATUS, 0);
    check(rd, 32'h2);
    apb(1, ADDR_MODE, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check(32'(pat_out), 32'h0);
    apb(1, ADDR_CTRL57, 0);
    repeat (4) send(0);
    @(posedge clk);
    ce           <= 1'b0;
    smp_in.valid <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(rx_count), 32'd4);
    ce           <= 1'b1;
    smp_in.valid <= 1'b0;
    for (k = 2; k <= 10; k++) begin
      g = 1.0 - 2.0 ** (-k) + 2.0 ** (-2 * k) - 2.0 ** (-3 * k);
      grp3 <= 1'b1;
      apb(1, ADDR_CTRL57, (k << 1) | 1);
      apb(0, ADDR_STATUS, 0);
      check(rd, 32'h1);
      repeat (8) send(1);
    end
    apb(1, ADDR_CTRL57, 0);
    apb(0, ADDR_STATUS, 0);
    check(rd, 32'h4);
    grp3 <= 1'b0;
    repeat (3) send(0);
    check(32'(rx_count), 32'd79);
    finish_test;
  end
endmodule // hpt_top_test
`default_nettype wire
